// [include/dssc_pkg.sv]
// constants, modes and register map of the debug state speed control block
// assumes one core clock; all debug and memory qualifiers arrive on that clock
package dssc_pkg;

  // ==========================================================
  // scan chain layout
  localparam int DSSC_CHAIN_LEN   = 67;
  localparam int DSSC_SEL_BIT     = 32;
  // shift clocks that must pass between two debug-speed core clocks
  localparam logic [6:0] DSSC_SCAN_GAP = 7'h43;
  // instruction fetches masked after leaving a breakpoint
  localparam int DSSC_MASK_FETCHES = 3;

  // ==========================================================
  // register map, byte addresses on the bus
  localparam logic [7:0] DSSC_ADR_CTRL   = 8'h00;
  localparam logic [7:0] DSSC_ADR_STATUS = 8'h04;
  // control fields
  localparam int DSSC_CTRL_HALT = 0;
  localparam logic DSSC_CTRL_HALT_RST = 1'h0;
  // status fields
  localparam int DSSC_ST_DEBUG   = 0;
  localparam int DSSC_ST_SYSRUN  = 1;
  localparam int DSSC_ST_MASK    = 2;
  localparam int DSSC_ST_SYSTEM_ACCESS_COMPLETE = 3;
  localparam int DSSC_ST_COMPR   = 4;
  localparam int DSSC_ST_B5      = 5;

  // ==========================================================
  // core operating modes
  typedef enum logic [1:0] {
    DSSC_NORMAL = 2'b00,
    DSSC_DEBUG  = 2'b01,
    DSSC_SYSRUN = 2'b10
  } dssc_mode_t;

endpackage

// [design/dssc_sync2.sv]
// two flip-flop synchroniser for one level from outside the clock domain
// assumes nothing of the source except that it is a level
`timescale 1ns/1ps
module dssc_sync2
  import dssc_pkg::*;
(
  input  wire logic core_clk_in,
  input  wire logic resetn_in,
  input  wire logic async_in,
  output logic      sync_out
);

  typedef struct packed {
    logic ff1;
    logic ff2;
  } dssc_sync_t;

  dssc_sync_t st_reg;
  dssc_sync_t st_next;

  // ==========================================================
  // the first stage feeds only the second
  always_comb
  begin
    st_next     = st_reg;
    st_next.ff1 = async_in;
    st_next.ff2 = st_reg.ff1;
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign sync_out = st_reg.ff2;

endmodule

// [design/dssc_fetch_mask.sv]
// holds a mask level across a fixed number of instruction fetches
// assumes fetch_in is a one-cycle pulse per completed fetch
`timescale 1ns/1ps
module dssc_fetch_mask
  import dssc_pkg::*;
#(
  parameter int COUNT = DSSC_MASK_FETCHES
)
(
  input  wire logic core_clk_in,
  input  wire logic resetn_in,
  input  wire logic start_in,
  input  wire logic fetch_in,
  output logic      active_out
);

  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

  typedef struct packed {
    logic          active;
    logic [CW-1:0] cnt;
  } dssc_mask_t;

  dssc_mask_t st_reg;
  dssc_mask_t st_next;

  // ==========================================================
  // counting
  always_comb
  begin
    st_next = st_reg;
    if (start_in)
    begin
      st_next.active = 1'b1;
      st_next.cnt    = '0;
    end
    else if (st_reg.active && fetch_in)
    begin
      // drops exactly after the last masked fetch, never later
      if (st_reg.cnt == LAST)
        st_next.active = 1'b0;
      st_next.cnt = st_reg.cnt + CW'(1);
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign active_out = st_reg.active;

  AST_MASK_STARTS: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    start_in |=> active_out)
    else $error("mask not raised after start");

  AST_MASK_ENDS: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (active_out && fetch_in && !start_in && st_reg.cnt == LAST) |=> !active_out)
    else $error("mask not dropped after last fetch");

endmodule

// [design/dssc_core.sv]
// debug state speed control: clock qualification, system-speed runs, resume
// assumes a tap controller on the same clock supplies the chain strobes
//
// How it works
// - status bit 4 high means compressed-state entry; bits 4,5 low mean 32-bit.
// - in debug state any mode may change to any other mode.
// - a debug-speed core clock needs 67 shift clocks since the previous one.
// - chain bit 32 selects system speed for the scanned instruction.
// - resume instruction and run-test/idle entry start memory-enabled execution.
// - after the system-speed instruction, back to debug enable, ack high.
// - status bit 3 flags system-speed completion; debugger polls it.
// - select bit returns low after a system-speed access.
// - resume returns chain to system operation and memory clock enable; the chain flag rises only on exit, a system-speed run keeps it low.
// - resumption happens only on entry to run-test/idle.
// - debug acknowledge is high while in debug state.
// - pipeline flushed on debug entry; refill after exit.
// - after breakpoint exit, ack stays high over three fetches.
// - ack high in system run, low after its accesses, high again on return.
// - core clock qualified by memory enable normally, debug enable in debug.
// - first select capture after entry shows cause: low break, high watch.
`timescale 1ns/1ps
module dssc_core
  import dssc_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        resetn_in,
  // classic wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  // clock qualifiers and core events
  input  wire logic        memory_clock_enable_in,
  input  wire logic        debug_clock_enable_in,
  input  wire logic        break_hit_in,
  input  wire logic        watch_hit_in,
  input  wire logic        ext_debug_request_in,
  input  wire logic        core_compressed_in,
  input  wire logic        fetch_in,
  input  wire logic        sys_mem_done_in,
  input  wire logic        sys_instr_done_in,
  // chain and tap strobes
  input  wire logic        scan_shift_in,
  input  wire logic        scan_capture_in,
  input  wire logic        scan_update_in,
  input  wire logic        scan_select_in,
  input  wire logic        scan_branch_in,
  input  wire logic        tap_restart_sel_in,
  input  wire logic        tap_run_idle_in,
  // outputs
  output logic             core_clock_enable_out,
  output logic             debug_acknowledge_out,
  output logic             system_speed_select_out,
  output logic             system_access_complete_out,
  output logic             pipeline_flush_out,
  output logic             any_mode_change_out,
  output logic             chain_system_mode_out
);

  typedef struct packed {
    dssc_mode_t  mode;
    logic        halt;
    logic        wb_ack;
    logic [31:0] rdata;
    logic        ce;
    logic        ack;
    logic        flush;
    logic        sso;
    logic        compl;
    logic        compr;
    logic        watch;
    logic        bp;
    logic        first_cap;
    logic        sel;
    logic        prev_sel;
    logic        prev_br;
    logic        armed;
    logic        arm_exit;
    logic        rti_prev;
    logic        mem_done;
    logic        chain_sys;
    logic        mchg;
    logic [6:0]  gap;
  } dssc_state_t;

  dssc_state_t st_reg;
  dssc_state_t st_next;

  logic ext_req;
  logic mask_active;
  logic mask_start;
  logic enter;
  logic rti_rise;
  logic resume;
  logic wb_acc;
  logic [31:0] status;

  // ==========================================================
  // helpers
  dssc_sync2 u_req_sync (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .async_in    (ext_debug_request_in),
    .sync_out    (ext_req)
  );

  dssc_fetch_mask #(
    .COUNT (DSSC_MASK_FETCHES)
  ) u_mask (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .start_in    (mask_start),
    .fetch_in    (fetch_in),
    .active_out  (mask_active)
  );

  always_comb
  begin
    status = '0;
    status[DSSC_ST_DEBUG]   = (st_reg.mode == DSSC_DEBUG);
    status[DSSC_ST_SYSRUN]  = (st_reg.mode == DSSC_SYSRUN);
    status[DSSC_ST_MASK]    = mask_active;
    status[DSSC_ST_SYSTEM_ACCESS_COMPLETE] = st_reg.compl;
    status[DSSC_ST_COMPR]   = st_reg.compr;
    status[DSSC_ST_B5]      = 1'b0;
  end

  assign enter    = break_hit_in | watch_hit_in | ext_req | st_reg.halt;
  assign rti_rise = tap_run_idle_in & ~st_reg.rti_prev;
  // resume only on the entry edge, so prepared cores start together
  assign resume   = (st_reg.mode == DSSC_DEBUG) & st_reg.armed
                    & tap_restart_sel_in & rti_rise;
  assign wb_acc   = wb_cyc_in & wb_stb_in & st_reg.wb_ack;
  assign mask_start = resume & st_reg.arm_exit & st_reg.bp;

  // ==========================================================
  // next state
  always_comb
  begin
    st_next          = st_reg;
    st_next.flush    = 1'b0;
    st_next.rti_prev = tap_run_idle_in;

    // bus slave: ack the cycle after the strobe, act at the acked edge
    st_next.wb_ack = wb_cyc_in & wb_stb_in & ~st_reg.wb_ack;
    if (wb_cyc_in & wb_stb_in & ~st_reg.wb_ack)
    begin
      unique case (wb_adr_in)
        DSSC_ADR_CTRL:   st_next.rdata = {31'h0, st_reg.halt};
        DSSC_ADR_STATUS: st_next.rdata = status;
        default:         st_next.rdata = 32'h0;
      endcase
    end
    if (wb_acc & wb_we_in & wb_sel_in[0] & (wb_adr_in == DSSC_ADR_CTRL))
      st_next.halt = wb_dat_in[DSSC_CTRL_HALT];

    // write one to clear completion; a completion the same cycle wins
    if (wb_acc & wb_we_in & wb_sel_in[0] & (wb_adr_in == DSSC_ADR_STATUS)
        & wb_dat_in[DSSC_ST_SYSTEM_ACCESS_COMPLETE])
      st_next.compl = 1'b0;

    unique case (st_reg.mode)
      DSSC_NORMAL:
      begin
        if (enter)
        begin
          st_next.mode      = DSSC_DEBUG;
          st_next.flush     = 1'b1;
          st_next.compr     = core_compressed_in;
          st_next.watch     = watch_hit_in;
          st_next.bp        = break_hit_in & ~watch_hit_in;
          st_next.first_cap = 1'b1;
          st_next.armed     = 1'b0;
          st_next.prev_sel  = 1'b0;
          st_next.chain_sys = 1'b0;
          st_next.gap       = '0;
          st_next.halt      = 1'b0;
        end
      end
      DSSC_DEBUG:
      begin
        // slow stepping: the core sees one clock per full chain shift
        if (st_reg.ce)
          st_next.gap = '0;
        else if (scan_shift_in && st_reg.gap != DSSC_SCAN_GAP)
          st_next.gap = st_reg.gap + 7'h01;
        if (scan_capture_in)
        begin
          st_next.sso       = st_reg.first_cap ? st_reg.watch : st_reg.sel;
          st_next.first_cap = 1'b0;
        end
        if (scan_update_in)
        begin
          st_next.sel      = scan_select_in;
          st_next.prev_sel = scan_select_in;
          st_next.prev_br  = scan_branch_in;
          // low-select instruction then high-select no-op arms a run
          st_next.armed    = scan_select_in & ~st_reg.prev_sel;
          st_next.arm_exit = st_reg.prev_br;
        end
        if (resume)
        begin
          st_next.armed = 1'b0;
          if (st_reg.arm_exit)
          begin
            st_next.mode      = DSSC_NORMAL;
            st_next.chain_sys = 1'b1;
          end
          else
          begin
            st_next.mode     = DSSC_SYSRUN;
            st_next.mem_done = 1'b0;
            // a fresh run starts with completion low so polling sees this run only
            st_next.compl    = 1'b0;
          end
        end
      end
      DSSC_SYSRUN:
      begin
        if (sys_mem_done_in)
          st_next.mem_done = 1'b1;
        if (sys_instr_done_in)
        begin
          st_next.mode     = DSSC_DEBUG;
          st_next.compl    = 1'b1;
          st_next.sel      = 1'b0;
          st_next.sso      = 1'b0;
          st_next.prev_sel = 1'b0;
          st_next.gap      = '0;
        end
      end
      default:
        st_next.mode = DSSC_NORMAL;
    endcase

    // qualifier and acknowledge follow the mode being entered
    if (st_next.mode == DSSC_DEBUG)
      st_next.ce = debug_clock_enable_in & (st_reg.gap == DSSC_SCAN_GAP)
                   & (st_reg.mode == DSSC_DEBUG) & ~st_reg.ce;
    else
      st_next.ce = memory_clock_enable_in;
    st_next.ack = (st_next.mode == DSSC_DEBUG)
                  | ((st_next.mode == DSSC_SYSRUN) & ~st_next.mem_done)
                  | mask_start | (mask_active & (st_reg.mode == DSSC_NORMAL));
    st_next.mchg = (st_next.mode == DSSC_DEBUG);
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      st_reg      <= '0;
      st_reg.mode <= DSSC_NORMAL;
      st_reg.halt <= DSSC_CTRL_HALT_RST;
    end
    else
      st_reg <= st_next;
  end

  // ==========================================================
  // outputs
  assign wb_dat_out                 = st_reg.rdata;
  assign wb_ack_out                 = st_reg.wb_ack;
  assign core_clock_enable_out      = st_reg.ce;
  assign debug_acknowledge_out      = st_reg.ack;
  assign system_speed_select_out    = st_reg.sso;
  assign system_access_complete_out = st_reg.compl;
  assign pipeline_flush_out         = st_reg.flush;
  assign any_mode_change_out        = st_reg.mchg;

  assign chain_system_mode_out = st_reg.chain_sys;

  // ==========================================================
  // checks
  AST_FLUSH_ENTRY: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (st_reg.mode == DSSC_NORMAL && enter) |=> (pipeline_flush_out && st_reg.mode == DSSC_DEBUG))
    else $error("no flush on debug entry");

  AST_ACK_DEBUG: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (st_reg.mode == DSSC_DEBUG) |-> debug_acknowledge_out)
    else $error("ack low in debug state");

  AST_SEL_CLEARED: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (st_reg.mode == DSSC_SYSRUN && sys_instr_done_in)
    |=> (!st_reg.sel && !system_speed_select_out && st_reg.mode == DSSC_DEBUG))
    else $error("select not cleared on return");

  AST_COMPLETE: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (st_reg.mode == DSSC_SYSRUN && sys_instr_done_in) |=> system_access_complete_out [*2])
    else $error("completion flag not held");

  AST_RESUME_RTI: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (st_reg.mode != DSSC_DEBUG && $past(st_reg.mode) == DSSC_DEBUG)
    |-> $past(tap_run_idle_in && !st_reg.rti_prev && tap_restart_sel_in))
    else $error("resume outside run-test/idle entry");

  AST_STEP_GAP: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    ($past(st_reg.mode) == DSSC_DEBUG && st_reg.mode == DSSC_DEBUG && core_clock_enable_out)
    |-> $past(st_reg.gap) == DSSC_SCAN_GAP)
    else $error("debug step before full chain shift");

  AST_MEM_QUAL: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    ($past(resetn_in) && st_reg.mode == DSSC_NORMAL && $past(st_reg.mode) == DSSC_NORMAL)
    |-> core_clock_enable_out == $past(memory_clock_enable_in))
    else $error("normal clock not memory qualified");

  AST_ACK_NORMAL: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (st_reg.mode == DSSC_NORMAL && $past(st_reg.mode) == DSSC_NORMAL && !$past(mask_active))
    |-> !debug_acknowledge_out)
    else $error("ack high in normal run");

  AST_FIRST_CAP: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (st_reg.mode == DSSC_DEBUG && scan_capture_in && st_reg.first_cap)
    |=> system_speed_select_out == $past(st_reg.watch))
    else $error("first capture does not show entry cause");

  AST_SYS_ACK: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (st_reg.mode == DSSC_SYSRUN && st_reg.mem_done && !sys_instr_done_in)
    |=> !debug_acknowledge_out)
    else $error("ack high after system accesses");

endmodule

// [tb/dssc_dbg_model.sv]
// debugger model: chain strobes, tap restart selection and run-test/idle
// assumes the bench calls its tasks; every change follows a core clock edge
`timescale 1ns/1ps
module dssc_dbg_model
  import dssc_pkg::*;
(
  input  wire logic clk_in,
  output logic      tck_en_out,
  output logic      shift_out,
  output logic      capture_out,
  output logic      update_out,
  output logic      select_out,
  output logic      branch_out,
  output logic      restart_sel_out,
  output logic      run_idle_out
);
  initial
  begin
    tck_en_out = 1'h0;
    shift_out = 1'h0;
    capture_out = 1'h0;
    update_out = 1'h0;
    select_out = 1'h1;
    branch_out = 1'h1;
    restart_sel_out = 1'h0;
    run_idle_out = 1'h0;
  end

  // ==========================================================
  // chain access
  // select and branch mean nothing outside update, so they flip afterwards
  task automatic scan_instr(input logic sel, input logic br);
    @(posedge clk_in);
    update_out <= 1'h1;
    select_out <= sel;
    branch_out <= br;
    @(posedge clk_in);
    update_out <= 1'h0;
    select_out <= ~sel;
    branch_out <= ~br;
  endtask

  task automatic capture();
    @(posedge clk_in);
    capture_out <= 1'h1;
    @(posedge clk_in);
    capture_out <= 1'h0;
  endtask

  // n shift clocks, then one cycle of debug clock enable
  task automatic step(input int n);
    @(posedge clk_in);
    shift_out <= 1'h1;
    repeat (n) @(posedge clk_in);
    shift_out <= 1'h0;
    tck_en_out <= 1'h1;
    @(posedge clk_in);
    tck_en_out <= 1'h0;
  endtask

  // ==========================================================
  // sequences
  // only a load or store carries the system-speed request
  task automatic sys_access();
    scan_instr(1'h0, 1'h0);
    scan_instr(1'h1, 1'h0);
  endtask

  task automatic exit_seq();
    scan_instr(1'h0, 1'h1);
    scan_instr(1'h1, 1'h0);
    step(67);
  endtask

  task automatic select_restart();
    @(posedge clk_in);
    restart_sel_out <= 1'h1;
  endtask

  task automatic enter_idle();
    @(posedge clk_in);
    run_idle_out <= 1'h1;
    @(posedge clk_in);
    @(posedge clk_in);
    run_idle_out <= 1'h0;
  endtask

  task automatic reselect_intest();
    @(posedge clk_in);
    restart_sel_out <= 1'h0;
  endtask
endmodule

// [tb/tb_top.sv]
// self-checking bench for the debug state speed control block
// assumes a 125 MHz core clock and the debugger model beside the core
`timescale 1ns/1ps
module tb_top
  import dssc_pkg::*;
;
  // ==========================================================
  // stimulus and observation
  logic        core_clk_in = 1'h0;
  logic        resetn_in = 1'h0;
  logic        wb_cyc_in = 1'h0;
  logic        wb_stb_in = 1'h0;
  logic        wb_we_in = 1'h0;
  logic [7:0]  wb_adr_in = 8'h00;
  logic [3:0]  wb_sel_in = 4'h0;
  logic [31:0] wb_dat_in = 32'h0;
  logic [31:0] wb_dat_out;
  logic        wb_ack_out;
  logic        memory_clock_enable_in = 1'h1;
  logic        ext_debug_request_in = 1'h0;
  logic        core_compressed_in = 1'h0;
  logic [4:0]  ev = 5'h00;
  wire         dce, shf, cap, upd, ssel, sbr, rsel, ridle;
  wire  [6:0]  obs;
  int          checks = 0;
  int          miscompares = 0;
  int          cycles = 0;

  always #4 core_clk_in = ~core_clk_in;

  dssc_core u_dssc_core (
    .core_clk_in, .resetn_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
    .wb_dat_in, .wb_dat_out, .wb_ack_out, .memory_clock_enable_in,
    .debug_clock_enable_in(dce), .break_hit_in(ev[0]), .watch_hit_in(ev[1]),
    .ext_debug_request_in, .core_compressed_in, .fetch_in(ev[2]),
    .sys_mem_done_in(ev[3]), .sys_instr_done_in(ev[4]), .scan_shift_in(shf),
    .scan_capture_in(cap), .scan_update_in(upd), .scan_select_in(ssel), .scan_branch_in(sbr),
    .tap_restart_sel_in(rsel), .tap_run_idle_in(ridle), .core_clock_enable_out(obs[0]),
    .debug_acknowledge_out(obs[1]), .system_speed_select_out(obs[2]),
    .system_access_complete_out(obs[3]), .pipeline_flush_out(obs[4]),
    .any_mode_change_out(obs[5]), .chain_system_mode_out(obs[6])
  );

  dssc_dbg_model u_dssc_dbg_model (
    .clk_in(core_clk_in), .tck_en_out(dce), .shift_out(shf), .capture_out(cap),
    .update_out(upd), .select_out(ssel), .branch_out(sbr), .restart_sel_out(rsel),
    .run_idle_out(ridle)
  );

  // ==========================================================
  // checking helpers; outputs are read before the edge's own updates land
  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_obs(input string what, input int idx, input logic v, input int n);
    int k;
    k = 0;
    while (obs[idx] !== v && k < n)
    begin
      @(posedge core_clk_in);
      k++;
    end
    chk(what, {31'h0, v}, {31'h0, obs[idx]});
  endtask

  task automatic hold_obs(input string what, input int idx, input logic v, input int n);
    logic seen;
    seen = v;
    repeat (n)
    begin
      @(posedge core_clk_in);
      if (obs[idx] !== v)
        seen = obs[idx];
    end
    chk(what, {31'h0, v}, {31'h0, seen});
  endtask

  task automatic pulse(input int i);
    @(posedge core_clk_in);
    ev[i] <= 1'h1;
    @(posedge core_clk_in);
    ev[i] <= 1'h0;
  endtask

  // ==========================================================
  // classic wishbone master; unbounded wait for ack, the bench timeout catches a slave that never answers
  task automatic xfer(input logic we, input logic [3:0] sel, input logic [7:0] adr,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge core_clk_in);
    wb_cyc_in <= 1'h1;
    wb_stb_in <= 1'h1;
    wb_we_in <= we;
    wb_sel_in <= sel;
    wb_adr_in <= adr;
    wb_dat_in <= wd;
    @(posedge core_clk_in);
    // no bound of its own; ack or the bench timeout ends this wait
    while (wb_ack_out !== 1'h1)
      @(posedge core_clk_in);
    rd = wb_dat_out;
    wb_cyc_in <= 1'h0;
    wb_stb_in <= 1'h0;
    chk("bus ack", 32'h1, {31'h0, wb_ack_out});
  endtask

  task automatic wb_wr(input logic [3:0] sel, input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] unused;
    xfer(1'h1, sel, adr, d, unused);
  endtask

  task automatic wb_rd(input string what, input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    xfer(1'h0, 4'hf, adr, 32'h0, d);
    chk(what, exp, d);
  endtask

  task automatic leave_debug();
    u_dssc_dbg_model.exit_seq();
    u_dssc_dbg_model.select_restart();
    hold_obs("no resume before idle", 6, 1'h0, 4);
    u_dssc_dbg_model.enter_idle();
    wait_obs("chain system", 6, 1'h1, 3);
    wait_obs("ce memory", 0, 1'h1, 3);
    chk("mode change off", 32'h0, {31'h0, obs[5]});
    u_dssc_dbg_model.reselect_intest();
  endtask

  always @(posedge core_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      miscompares++;
      end_sim();
    end
  end

  // ==========================================================
  // tests
  initial
  begin
    repeat (20) @(posedge core_clk_in);
    resetn_in <= 1'h1;
    hold_obs("ack after reset", 1, 1'h0, 4);
    wait_obs("ce normal", 0, 1'h1, 3);
    memory_clock_enable_in <= 1'h0;
    wait_obs("ce stalled", 0, 1'h0, 3);
    memory_clock_enable_in <= 1'h1;
    wb_rd("ctrl reset", DSSC_ADR_CTRL, 32'h0);
    wb_rd("status reset", DSSC_ADR_STATUS, 32'h0);
    wb_wr(4'hf, DSSC_ADR_STATUS, 32'h37);
    wb_rd("status read only", DSSC_ADR_STATUS, 32'h0);
    wb_wr(4'hf, 8'h40, 32'h1);
    wb_rd("unmapped", 8'h40, 32'h0);
    $display("test reset and registers done");

    pulse(1);
    wait_obs("ack on watch", 1, 1'h1, 3);
    wb_rd("status watch entry", DSSC_ADR_STATUS, 32'h1);
    u_dssc_dbg_model.capture();
    wait_obs("cause watch", 2, 1'h1, 3);
    u_dssc_dbg_model.sys_access();
    u_dssc_dbg_model.select_restart();
    hold_obs("no run before idle", 0, 1'h0, 4);
    memory_clock_enable_in <= 1'h0;
    u_dssc_dbg_model.enter_idle();
    hold_obs("ack in system run", 1, 1'h1, 3);
    memory_clock_enable_in <= 1'h1;
    wait_obs("ce system speed", 0, 1'h1, 3);
    wb_rd("status running", DSSC_ADR_STATUS, 32'h2);
    pulse(3);
    wait_obs("ack low after accesses", 1, 1'h0, 3);
    pulse(4);
    wait_obs("ack back in debug", 1, 1'h1, 3);
    wait_obs("complete", 3, 1'h1, 2);
    wait_obs("select cleared", 2, 1'h0, 2);
    wait_obs("ce debug enable", 0, 1'h0, 2);
    u_dssc_dbg_model.reselect_intest();
    wb_rd("status complete", DSSC_ADR_STATUS, 32'h9);
    wb_wr(4'hf, DSSC_ADR_STATUS, 32'h8);
    wb_rd("status cleared", DSSC_ADR_STATUS, 32'h1);
    leave_debug();
    wait_obs("ack after watch exit", 1, 1'h0, 4);
    $display("test system speed access done");

    core_compressed_in <= 1'h1;
    pulse(0);
    wait_obs("flush on entry", 4, 1'h1, 3);
    wait_obs("ack on break", 1, 1'h1, 2);
    chk("mode change on", 32'h1, {31'h0, obs[5]});
    chk("chain in debug", 32'h0, {31'h0, obs[6]});
    wb_rd("status compressed", DSSC_ADR_STATUS, 32'h11);
    core_compressed_in <= 1'h0;
    u_dssc_dbg_model.capture();
    hold_obs("cause break", 2, 1'h0, 3);
    u_dssc_dbg_model.step(66);
    hold_obs("no step at 66", 0, 1'h0, 4);
    u_dssc_dbg_model.step(1);
    wait_obs("step at 67", 0, 1'h1, 3);
    leave_debug();
    pulse(2);
    pulse(2);
    hold_obs("mask over fetches", 1, 1'h1, 2);
    pulse(2);
    wait_obs("mask ends", 1, 1'h0, 3);
    $display("test breakpoint exit done");

    wb_wr(4'he, DSSC_ADR_CTRL, 32'h1);
    hold_obs("halt byte off", 1, 1'h0, 3);
    wb_wr(4'hf, DSSC_ADR_CTRL, 32'h1);
    wait_obs("halt entry", 1, 1'h1, 3);
    wb_rd("halt self clear", DSSC_ADR_CTRL, 32'h0);
    leave_debug();
    wait_obs("ack after halt exit", 1, 1'h0, 4);
    ext_debug_request_in <= 1'h1;
    wait_obs("request entry", 1, 1'h1, 6);
    ext_debug_request_in <= 1'h0;
    leave_debug();
    wait_obs("ack after request exit", 1, 1'h0, 4);
    $display("test halt and request done");
    end_sim();
  end
endmodule
